// *** src/errrd_pkg.sv ***
// Constants for the error register readback block of the SPI slave.
// Assumes a 16-bit SPI word, MSB first, mode 1 style (drive on rise, sample on fall).
// Summary of operation
// - Bits 10 to 8 select a register whose value comes back in the next frame, not this one.
// - The low eight bits of a read command are ignored whatever they hold.
// - The reply carries zero extension bits, the echoed selector in 10 to 8 and the value in 7 to 0.
// - Selectors 0 to 4 pick the five error correction registers, 200 mV up to 1000 mV in order.
// - Each channel has its own error register set, chosen by the channel select bit.
// - Command codes 1101, 1110 and 1111 are invalid and their reply is never all ones.
package errrd_pkg;
    localparam int FRAME_BITS = 16;
    localparam int CH_BIT = 15;
    localparam int CMD_HI = 14;
    localparam int CMD_LO = 11;
    localparam int SEL_HI = 10;
    localparam int SEL_LO = 8;
    localparam int VAL_HI = 7;
    localparam logic [3:0] CMD_READ_ERR = 4'hC;
    localparam logic [3:0] CMD_BAD_0 = 4'hD;
    localparam logic [3:0] CMD_BAD_1 = 4'hE;
    localparam logic [3:0] CMD_BAD_2 = 4'hF;
    localparam logic [2:0] SEL_REV = 3'h5;
    localparam logic [2:0] SEL_LAST_ERR = 3'h4;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
    localparam logic [15:0] REPLY_IDLE = 16'h0000;
    // Value is arbitrary
    localparam logic [7:0] REVISION_DEFAULT = 8'h11;
endpackage

// *** src/errrd_readback.sv ***
// Read error register command decoder, SPI side plus system side.
// Assumes SPI clock idles low, data out changes on rising and is sampled on falling edge;
// error correction values arrive as a flat bus on the system clock, five bytes per channel.
`timescale 1ns/10ps
`default_nettype none
module errrd_readback #(
    parameter logic [7:0] REVISION = errrd_pkg::REVISION_DEFAULT
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic spi_sclk,
    input wire logic spi_cs_n,
    input wire logic spi_mosi,
    output logic spi_miso,
    output logic spi_miso_oe_n,
    input wire logic [39:0] err_ch0,
    input wire logic [39:0] err_ch1
);

    // Receive side, clocked by falling sclk
    logic [15:0] rx_reg;
    logic [15:0] rx_next;
    logic [4:0] cnt_reg;
    logic [4:0] cnt_next;
    logic done_tgl_reg;
    logic done_tgl_next;
    logic [15:0] frame_reg;
    logic [15:0] frame_next;

    // Transmit side, clocked by rising sclk
    logic [15:0] tx_reg;
    logic [15:0] tx_next;
    logic first_bit_reg;
    logic first_bit_next;

    // Reply word as captured when chip select falls
    logic [15:0] reply_s1_reg;

    // System side state
    logic [15:0] reply_reg;
    logic [15:0] reply_next;
    logic tgl_sync;
    logic tgl_seen_reg;
    logic tgl_seen_next;
    logic frame_evt;

    // Decode nets
    logic [3:0] cmd;
    logic [2:0] sel;
    logic ch;
    logic is_read;
    logic is_bad;
    logic [7:0] byte_ch0;
    logic [7:0] byte_ch1;
    logic [7:0] err_byte;
    logic [7:0] value;

    // ------------------------------------------------------------
    // Link side
    // ------------------------------------------------------------

    // Shift in on each falling edge; the sixteenth edge closes the frame
    always_comb begin
        rx_next = {rx_reg[14:0], spi_mosi};
        cnt_next = cnt_reg + 5'h01;
        done_tgl_next = done_tgl_reg;
        frame_next = frame_reg;
        if (cnt_reg == 5'(errrd_pkg::FRAME_BITS - 1)) begin
            done_tgl_next = ~done_tgl_reg; // Toggle, not pulse: sclk may stop right after
            frame_next = rx_next;
        end
    end

    // Chip select clears the bit count so a cut frame does not misalign the next
    always_ff @(negedge spi_sclk or posedge spi_cs_n) begin
        if (spi_cs_n) begin
            cnt_reg <= 5'h00;
            rx_reg <= 16'h0000;
        end else begin
            cnt_reg <= cnt_next;
            rx_reg <= rx_next;
        end
    end

    // Completed word and its toggle survive chip select; only reset clears them
    always_ff @(negedge spi_sclk or posedge rst) begin
        if (rst) begin
            done_tgl_reg <= 1'b0;
            frame_reg <= 16'h0000;
        end else begin
            done_tgl_reg <= done_tgl_next;
            frame_reg <= frame_next;
        end
    end

    // Transmit: first rise loads the reply, later rises shift it
    // Bit 15 must stand until the first fall, so the load keeps it on top
    always_comb begin
        first_bit_next = 1'b0;
        if (first_bit_reg) begin
            tx_next = reply_s1_reg;
        end else begin
            tx_next = {tx_reg[14:0], 1'b0};
        end
    end

    // Deselect rearms the load for the next frame
    always_ff @(posedge spi_sclk or posedge spi_cs_n) begin
        if (spi_cs_n) begin
            tx_reg <= 16'h0000;
            first_bit_reg <= 1'b1;
        end else begin
            tx_reg <= tx_next;
            first_bit_reg <= first_bit_next;
        end
    end

    // Reply crosses on the chip select edge
    // Safe because the system side settles it well before the next select
    always_ff @(negedge spi_cs_n or posedge rst) begin
        if (rst) begin
            reply_s1_reg <= 16'h0000;
        end else begin
            reply_s1_reg <= reply_reg;
        end
    end

    // Output bit never moves on a falling edge, where the master samples
    always_comb begin
        if (first_bit_reg) begin
            spi_miso = reply_s1_reg[errrd_pkg::FRAME_BITS - 1];
        end else begin
            spi_miso = tx_reg[errrd_pkg::FRAME_BITS - 1];
        end
        spi_miso_oe_n = spi_cs_n;
    end

    // ------------------------------------------------------------
    // System side
    // ------------------------------------------------------------

    // Frame-done toggle crosses by two flip-flops
    errrd_sync errrd_sync_i (
        .clk(clk_sys),
        .rst(rst),
        .d(done_tgl_reg),
        .q(tgl_sync)
    );

    // Edge of the synchronised toggle marks one decoded frame
    always_comb begin
        tgl_seen_next = tgl_sync;
        frame_evt = tgl_sync ^ tgl_seen_reg;
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            tgl_seen_reg <= 1'b0;
        end else begin
            tgl_seen_reg <= tgl_seen_next;
        end
    end

    // One byte picker per channel bank
    errrd_byte_pick errrd_byte_pick_ch0_i (
        .bank(err_ch0),
        .sel(sel),
        .pick(byte_ch0)
    );

    errrd_byte_pick errrd_byte_pick_ch1_i (
        .bank(err_ch1),
        .sel(sel),
        .pick(byte_ch1)
    );

    // Field split of the captured command
    // frame_reg stays still for a whole frame after its toggle, so no extra capture
    always_comb begin
        cmd = frame_reg[errrd_pkg::CMD_HI:errrd_pkg::CMD_LO];
        sel = frame_reg[errrd_pkg::SEL_HI:errrd_pkg::SEL_LO];
        ch = frame_reg[errrd_pkg::CH_BIT];
        is_read = cmd == errrd_pkg::CMD_READ_ERR;
        is_bad = cmd == errrd_pkg::CMD_BAD_0 || cmd == errrd_pkg::CMD_BAD_1
                 || cmd == errrd_pkg::CMD_BAD_2;
    end

    // Register value by selector
    always_comb begin
        err_byte = ch ? byte_ch1 : byte_ch0;
        if (sel <= errrd_pkg::SEL_LAST_ERR) begin
            value = err_byte;
        end else if (sel == errrd_pkg::SEL_REV) begin
            value = REVISION;
        end else begin
            value = errrd_pkg::ZERO_BYTE;
        end
    end

    // Reply word, rebuilt once per decoded frame and held until the next
    always_comb begin
        reply_next = reply_reg;
        if (frame_evt) begin
            if (is_read) begin
                // Low command bits never reach the reply
                reply_next = {ch, errrd_pkg::CMD_READ_ERR[3:2],
                              2'b00, sel, value};
            end else if (is_bad) begin
                // All zero keeps clear of the all-ones word
                reply_next = errrd_pkg::REPLY_IDLE;
            end else begin
                // Other commands belong to other decoders
                reply_next = errrd_pkg::REPLY_IDLE;
            end
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            reply_reg <= errrd_pkg::REPLY_IDLE;
        end else begin
            reply_reg <= reply_next;
        end
    end
endmodule // errrd_readback

// Two flip-flop synchroniser for one slow level
// Only the second stage is read outside
module errrd_sync (
    input wire logic clk,
    input wire logic rst,
    input wire logic d,
    output logic q
);
    logic meta_reg;
    logic meta_next;
    logic q_reg;
    logic q_next;

    // Next values: plain shift
    always_comb begin
        meta_next = d;
        q_next = meta_reg;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_reg <= 1'b0;
            q_reg <= 1'b0;
        end else begin
            meta_reg <= meta_next;
            q_reg <= q_next;
        end
    end

    assign q = q_reg;
endmodule // errrd_sync

// Picks one error byte out of a five-byte bank
// Selectors past the last error register give zero; the caller overrides them
module errrd_byte_pick (
    input wire logic [39:0] bank,
    input wire logic [2:0] sel,
    output logic [7:0] pick
);
    // Byte k sits at bits 8k+7 down to 8k
    always_comb begin
        pick = errrd_pkg::ZERO_BYTE;
        if (sel <= errrd_pkg::SEL_LAST_ERR) begin
            pick = bank[(errrd_pkg::VAL_HI + 1) * int'(sel) +: (errrd_pkg::VAL_HI + 1)];
        end
    end
endmodule // errrd_byte_pick
`default_nettype wire

// *** dv/errrd_spi_master.sv ***
// SPI master model for the readback block, one 16-bit word per frame.
// Assumes the bench calls xfer; sclk stands still low between frames.
`timescale 1ns/10ps
`default_nettype none
module errrd_spi_master (
    output logic spi_sclk,
    output logic spi_cs_n,
    output logic spi_mosi,
    input wire logic spi_miso
);
    initial begin
        spi_sclk = 1'b0;
        spi_cs_n = 1'b1;
        spi_mosi = 1'b0;
    end
    // Drive on rise, sample on fall; the 3 ns offset keeps sclk off clk_sys edges unless the call starts 2 ns after a clk_sys edge
    task automatic xfer(input logic [15:0] cmd, output logic [15:0] rsp);
        #3 spi_cs_n = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            #80 spi_sclk = 1'b1;
            spi_mosi = cmd[i];
            #80 spi_sclk = 1'b0;
            rsp[i] = spi_miso;
        end
        #80 spi_cs_n = 1'b1;
        spi_mosi = ~spi_mosi; // Stale data would hide a late sample
        #200;
    endtask
endmodule // errrd_spi_master
`default_nettype wire

// *** dv/errrd_readback_assertions.sv ***
// Checker for the readback block, frame-level reply checks.
// Assumes mode 1 framing; reply bits are sampled on falling sclk.
`timescale 1ns/10ps
`default_nettype none
module errrd_readback_assertions #(
    parameter logic [7:0] REVISION = errrd_pkg::REVISION_DEFAULT
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic spi_sclk,
    input wire logic spi_cs_n,
    input wire logic spi_mosi,
    input wire logic spi_miso,
    input wire logic spi_miso_oe_n,
    input wire logic [39:0] err_ch0,
    input wire logic [39:0] err_ch1
);
    logic [4:0] cnt_reg;
    logic [15:0] mo_reg, mi_reg, cmd_reg, mo_w, mi_w, exp_w;
    logic [79:0] all_w;
    logic rd_w, end_w;
    // Whole words as seen at the 16th falling edge
    assign mo_w = {mo_reg[14:0], spi_mosi};
    assign mi_w = {mi_reg[14:0], spi_miso};
    assign end_w = !spi_cs_n && cnt_reg == 5'h0F;
    assign rd_w = cmd_reg[14:11] == errrd_pkg::CMD_READ_ERR;
    assign all_w = {err_ch1, err_ch0};
    assign exp_w = !rd_w ? 16'h0000 : cmd_reg[10:8] == 3'h5 ? {cmd_reg[15:8], REVISION} :
        cmd_reg[10:8] > 3'h5 ? {cmd_reg[15:8], 8'h00} :
        {cmd_reg[15:8], all_w[(cmd_reg[15] * 40 + cmd_reg[10:8] * 8) +: 8]};
    // Bit counter; a short frame never reaches the end count
    always_ff @(negedge spi_sclk or posedge spi_cs_n or posedge rst) begin
        if (rst || spi_cs_n) begin
            cnt_reg <= 5'h00;
            mo_reg <= 16'h0000;
            mi_reg <= 16'h0000;
        end else begin
            cnt_reg <= cnt_reg + 5'h01;
            mo_reg <= mo_w;
            mi_reg <= mi_w;
        end
    end
    // Last complete command, answered in the next frame
    always_ff @(negedge spi_sclk or posedge rst) begin
        if (rst) cmd_reg <= 16'h0000;
        else if (end_w) cmd_reg <= mo_w;
    end
    word_match_a: assert property (@(negedge spi_sclk) disable iff (rst) end_w |-> mi_w == exp_w)
        else $error("reply word differs from expected");
    never_ones_a: assert property (@(negedge spi_sclk) disable iff (rst) end_w |-> mi_w != 16'hFFFF)
        else $error("reply word is all ones");
    bad_zero_a: assert property (@(negedge spi_sclk) disable iff (rst)
        end_w && cmd_reg[14:11] > errrd_pkg::CMD_READ_ERR |-> mi_w == 16'h0000)
        else $error("invalid command reply not zero");
    echo_sel_a: assert property (@(negedge spi_sclk) disable iff (rst)
        end_w && rd_w |-> mi_w[12:8] == {2'h0, cmd_reg[10:8]})
        else $error("selector echo or extension wrong");
    chan_echo_a: assert property (@(negedge spi_sclk) disable iff (rst)
        end_w && rd_w |-> mi_w[15] == cmd_reg[15])
        else $error("channel bit not echoed");
    oe_follow_a: assert property (@(posedge clk_sys) disable iff (rst)
        $fell(spi_cs_n) |-> !spi_miso_oe_n && $past(spi_miso_oe_n))
        else $error("output enable does not follow select");
endmodule // errrd_readback_assertions
bind errrd_readback errrd_readback_assertions #(.REVISION(REVISION)) errrd_readback_assertions_i (.*);
`default_nettype wire

// *** dv/errrd_readback_tb.sv ***
// Testbench for the readback block through the SPI master model.
// Assumes error bytes are static and the default revision parameter.
`timescale 1ns/10ps
`default_nettype none
module errrd_readback_tb;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    wire sclk, cs_n, mosi, miso, oe_n;
    logic [39:0] err_ch0 = 40'hA1B2C3D4E5;
    logic [39:0] err_ch1 = 40'h5A6B7C8D9E;
    logic [15:0] prev = 16'h0000;
    logic [15:0] rsp;
    int miscompares = 0;
    int total_checks = 0;
    initial forever #5 clk_sys = ~clk_sys;
    errrd_readback errrd_readback_i (.clk_sys(clk_sys), .rst(rst), .spi_sclk(sclk),
        .spi_cs_n(cs_n), .spi_mosi(mosi), .spi_miso(miso), .spi_miso_oe_n(oe_n),
        .err_ch0(err_ch0), .err_ch1(err_ch1));
    errrd_spi_master errrd_spi_master_i (.spi_sclk(sclk), .spi_cs_n(cs_n), .spi_mosi(mosi),
        .spi_miso(miso));
    // Reply owed to a command, one frame later
    function automatic logic [15:0] expect_word(input logic [15:0] c);
        logic [7:0] b;
        b = c[10:8] == 3'h5 ? errrd_pkg::REVISION_DEFAULT : c[10:8] > 3'h5 ? 8'h00 :
            8'((c[15] ? err_ch1 : err_ch0) >> (8 * c[10:8]));
        return c[14:11] == errrd_pkg::CMD_READ_ERR ? {c[15:8], b} : 16'h0000;
    endfunction
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t reply %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic send(input logic [15:0] c);
        errrd_spi_master_i.xfer(c, rsp);
        check(rsp, expect_word(prev));
        prev = c;
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // Hang guard, far beyond the frame count used
    initial begin
        #200000 miscompares++;
        complete_run;
    end
    initial begin
        repeat (16) @(posedge clk_sys);
        @(negedge clk_sys) rst <= 1'b0;
        repeat (4) @(negedge clk_sys);
        for (int i = 0; i < 16; i++) send({i[3], 4'hC, i[2:0], 8'(i * 37)});
        $display("test readback done");
        for (int i = 13; i < 16; i++) send({1'b1, 4'(i), 3'h7, 8'hFF});
        send(16'h0000);
        $display("test invalid codes done");
        complete_run;
    end
endmodule // errrd_readback_tb
`default_nettype wire
